// >>> logic/tmc_timer.sv
// Purpose: common timer module: counter, two comparators, pins
// Assumes: bus and pins synchronous to ref_clk; high clock = ref_clk
// Notes:   low bytes of wide pairs go through one shared buffer

// How it works
// [R01] Counter equal to comparator raises interrupt, may clear, may drive pin
// [R02] Three-bit clock select picks system, high, sub or external clock
// [R03] External clock pin selected makes counter advance on its edges
// [R04] Separate interrupt flags for compare A and compare P matches
// [R05] External clock counts on rising or falling edge by selection
// [R06] External pin only taken by the timer while selected
// [R07] Compare output mode sets pin high, low or toggles on match
// [R08] PWM waveform leaves on the same output pins
// [R09] Pin choice bit routes output to first or second pin when enabled
// [R10] Upper four bits of pin select read as zero
// [R11] High bytes direct, low bytes only through shared buffer
// [R12] Low byte write of compare pair only loads the buffer
// [R13] High byte write updates high and copies buffer into low
// [R14] High byte read returns high and captures live low in buffer
// [R15] Low byte read returns the buffer contents
// [R16] Software writes low then high, reads high then low
// [R17] Counter and compare registers are ten bits wide here
// [R18] Counter increments once per active clock edge while enabled
module tmc_timer (
  input  wire logic              ref_clk,    // 100 MHz clock
  input  wire logic              sys_rst,    // sync reset, high
  input  wire tmc_pkg::tmc_bus_s bus,        // register requests
  output logic [7:0]             rdata,      // read data, next cycle
  input  wire logic              subTick,    // sub clock tick pulse
  input  wire logic              tckIn,      // timer_clock_input_pin
  output logic                   tckTaken,   // pin claimed by timer
  output tmc_pkg::tmc_pin_s      pinDrive,   // output pin drive
  output logic [3:0]             pinChoice,  // module3..0 pin choice
  output logic                   irq         // level interrupt
);
  import tmc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    tmc_byte_t  ctrl;
    tmc_byte_t  mode;
    // [R17] ten-bit counter and compares
    tmc_cnt_t   cnt;
    tmc_cnt_t   cmpA;
    tmc_cnt_t   cmpP;
    tmc_byte_t  lowBuf;
    logic [3:0] pinSel;
    logic [1:0] irqSt;
    logic [1:0] irqMsk;
    logic [5:0] pre;
    logic       tckPrev;
    logic       onPrev;
    logic       outLvl;
    tmc_byte_t  rd;
  } tmc_state_s;

  tmc_state_s st_r;
  tmc_state_s st_nxt;

  logic [2:0] ckSel;
  logic [1:0] opMode;
  logic [1:0] ioFn;
  logic       enOn;
  logic       tick;
  logic       hitA;
  logic       hitP;
  logic       clrA;
  logic       pwmLvl;

  // Upper bits of a 10-bit value as a byte
  function automatic tmc_byte_t hiByte(input tmc_cnt_t v);
    hiByte = {6'h00, v[CW-1:8]};
  endfunction

  assign ckSel  = st_r.ctrl[CTRL_CKL +: 3];
  assign enOn   = st_r.ctrl[CTRL_ON];
  assign opMode = st_r.mode[MODE_ML +: 2];
  assign ioFn   = st_r.mode[MODE_IOL +: 2];
  assign clrA   = st_r.mode[MODE_CLR];

  // ==========================================================
  // Clock source decode
  // [R02] source select
  always_comb begin
    case (ckSel)
      CK_SYS4: tick = (st_r.pre[1:0] == DIV4[1:0]);
      CK_SYS:  tick = 1'b1;
      CK_H16:  tick = (st_r.pre[3:0] == DIV16[3:0]);
      CK_H64:  tick = (st_r.pre == DIV64);
      CK_SUB:  tick = subTick;
      // [R03] [R05] external edge counting
      CK_EXTR: tick = tckIn & ~st_r.tckPrev;
      CK_EXTF: tick = ~tckIn & st_r.tckPrev;
      // Reserved code stops the counter
      default: tick = 1'b0;
    endcase
  end

  // [R06] claim shared pin only when chosen
  assign tckTaken = (ckSel == CK_EXTR) || (ckSel == CK_EXTF);

  // [R01] compare match on an active edge
  assign hitA = enOn && tick && (st_r.cnt == st_r.cmpA);
  assign hitP = enOn && tick && (st_r.cnt == st_r.cmpP);

  // Edge aligned PWM: active while below compare A
  assign pwmLvl = (st_r.cnt < st_r.cmpA);

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pre     = st_r.pre + 6'h01;
    st_nxt.tckPrev = tckIn;
    st_nxt.onPrev  = enOn;
    st_nxt.rd      = RST_BYTE;

    // [R18] count while enabled
    if (enOn && tick) begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
    // [R01] match clears counter when chosen
    if ((hitP && !clrA) || (hitA && clrA)) begin
      st_nxt.cnt = RST_CNT;
    end

    // [R07] compare output action on A match
    if (opMode == M_CMP && hitA) begin
      case (ioFn)
        IO_LOW:  st_nxt.outLvl = 1'b0;
        IO_HIGH: st_nxt.outLvl = 1'b1;
        IO_TOG:  st_nxt.outLvl = ~st_r.outLvl;
        default: st_nxt.outLvl = st_r.outLvl;
      endcase
    end
    // [R08] PWM on the same pins
    if (opMode == M_PWM) begin
      case (ioFn)
        2'h0:    st_nxt.outLvl = 1'b0;
        2'h1:    st_nxt.outLvl = 1'b1;
        2'h2:    st_nxt.outLvl = pwmLvl;
        default: st_nxt.outLvl = st_r.outLvl;
      endcase
    end
    // Turn-on restarts count and output level
    if (enOn && !st_r.onPrev) begin
      st_nxt.cnt    = RST_CNT;
      st_nxt.outLvl = st_r.mode[MODE_INI];
    end

    // Register reads; read of status clears it
    if (bus.rd) begin
      case (bus.addr)
        A_CTRL:   st_nxt.rd = st_r.ctrl;
        A_MODE:   st_nxt.rd = st_r.mode;
        // [R14] high read captures live low
        A_CNT_H: begin
          st_nxt.rd     = hiByte(st_r.cnt);
          st_nxt.lowBuf = st_r.cnt[7:0];
        end
        A_CMPA_H: begin
          st_nxt.rd     = hiByte(st_r.cmpA);
          st_nxt.lowBuf = st_r.cmpA[7:0];
        end
        A_CMPP_H: begin
          st_nxt.rd     = hiByte(st_r.cmpP);
          st_nxt.lowBuf = st_r.cmpP[7:0];
        end
        // [R15] [R11] low read returns buffer
        A_CNT_L, A_CMPA_L, A_CMPP_L: st_nxt.rd = st_r.lowBuf;
        // [R10] unimplemented bits zero
        A_PINSEL: st_nxt.rd = {4'h0, st_r.pinSel};
        A_IRQST: begin
          st_nxt.rd    = {6'h00, st_r.irqSt};
          st_nxt.irqSt = 2'h0;
        end
        A_IRQMSK: st_nxt.rd = {6'h00, st_r.irqMsk};
        default:  st_nxt.rd = RST_BYTE;
      endcase
    end

    // Register writes; counter bytes are read only
    if (bus.wr) begin
      case (bus.addr)
        A_CTRL:   st_nxt.ctrl = bus.wdata;
        A_MODE:   st_nxt.mode = bus.wdata;
        // [R12] low write lands in buffer only
        A_CMPA_L, A_CMPP_L: st_nxt.lowBuf = bus.wdata;
        // [R13] high write copies buffer to low
        A_CMPA_H: st_nxt.cmpA = {bus.wdata[1:0], st_r.lowBuf};
        A_CMPP_H: st_nxt.cmpP = {bus.wdata[1:0], st_r.lowBuf};
        A_PINSEL: st_nxt.pinSel = bus.wdata[3:0];
        A_IRQMSK: st_nxt.irqMsk = bus.wdata[1:0];
        default:  st_nxt.pinSel = st_r.pinSel;
      endcase
    end

    // [R04] two sticky sources; set beats read clear
    if (hitA) begin
      st_nxt.irqSt[IRQ_A] = 1'b1;
    end
    if (hitP) begin
      st_nxt.irqSt[IRQ_P] = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata     = st_r.rd;
  assign pinChoice = st_r.pinSel;
  assign irq       = |(st_r.irqSt & st_r.irqMsk);

  // [R09] route to one pin; other stays I/O
  // Timer/counter mode keeps pins released
  always_comb begin
    pinDrive.out = st_r.outLvl;
    pinDrive.oe0 = enOn && (opMode != M_TMR) && !st_r.pinSel[0];
    pinDrive.oe1 = enOn && (opMode != M_TMR) && st_r.pinSel[0];
  end
endmodule

// >>> pkg/tmc_pkg.sv
// Purpose: constants and carriers for the timer module shell
// Assumes: 8-bit register port, one ref_clk domain
// Notes:   counter, compare A and compare P are 10 bits wide
package tmc_pkg;
  // ==========================================================
  // Widths
  localparam int CW = 10;
  typedef logic [CW-1:0] tmc_cnt_t;
  typedef logic [7:0]    tmc_byte_t;
  typedef logic [3:0]    tmc_addr_t;

  // ==========================================================
  // Register offsets
  localparam tmc_addr_t A_CTRL   = 4'h0;
  localparam tmc_addr_t A_MODE   = 4'h1;
  localparam tmc_addr_t A_CNT_L  = 4'h2;
  localparam tmc_addr_t A_CNT_H  = 4'h3;
  localparam tmc_addr_t A_CMPA_L = 4'h4;
  localparam tmc_addr_t A_CMPA_H = 4'h5;
  localparam tmc_addr_t A_CMPP_L = 4'h6;
  localparam tmc_addr_t A_CMPP_H = 4'h7;
  localparam tmc_addr_t A_PINSEL = 4'h8;
  localparam tmc_addr_t A_IRQST  = 4'h9;
  localparam tmc_addr_t A_IRQMSK = 4'hA;

  // ==========================================================
  // Field positions
  localparam int CTRL_ON  = 3;   // control: enable bit
  localparam int CTRL_CKL = 4;   // control: clock select, 3 bits
  localparam int MODE_INI = 3;   // mode: initial output level
  localparam int MODE_IOL = 4;   // mode: pin function, 2 bits
  localparam int MODE_ML  = 6;   // mode: operating mode, 2 bits
  localparam int MODE_CLR = 0;   // mode: 1 clears on A, 0 on P
  localparam int IRQ_A    = 0;
  localparam int IRQ_P    = 1;

  // ==========================================================
  // Encodings
  localparam logic [2:0] CK_SYS4  = 3'h0;
  localparam logic [2:0] CK_SYS   = 3'h1;
  localparam logic [2:0] CK_H16   = 3'h2;
  localparam logic [2:0] CK_H64   = 3'h3;
  localparam logic [2:0] CK_SUB   = 3'h4;
  localparam logic [2:0] CK_EXTR  = 3'h6;
  localparam logic [2:0] CK_EXTF  = 3'h7;
  localparam logic [1:0] M_CMP    = 2'h0;
  localparam logic [1:0] M_PWM    = 2'h2;
  localparam logic [1:0] M_TMR    = 2'h3;
  localparam logic [1:0] IO_LOW   = 2'h1;
  localparam logic [1:0] IO_HIGH  = 2'h2;
  localparam logic [1:0] IO_TOG   = 2'h3;

  // ==========================================================
  // Reset values and prescale counts
  localparam tmc_byte_t RST_BYTE = 8'h00;
  localparam tmc_cnt_t  RST_CNT  = 10'h000;
  localparam logic [5:0] DIV4    = 6'h03;
  localparam logic [5:0] DIV16   = 6'h0F;
  localparam logic [5:0] DIV64   = 6'h3F;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic      wr;
    logic      rd;
    tmc_addr_t addr;
    tmc_byte_t wdata;
  } tmc_bus_s;

  typedef struct packed {
    logic out;   // level driven on the chosen pin
    logic oe0;   // first pin driven by the timer
    logic oe1;   // second pin driven by the timer
  } tmc_pin_s;
endpackage

// >>> tb/tmc_pin_model.sv
// Purpose: far side of the timer pins: external clock source
// Assumes: pin level moves just after a clock edge
// Notes:   unclaimed pin keeps changing, as its other user would
module tmc_pin_model (
  input  wire logic ref_clk,   // clock
  input  wire logic tckTaken,  // pin claimed by timer
  output logic      tckIn      // external clock pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Pin driving
  initial tckIn = 1'b0;
  always @(posedge ref_clk) begin
    if (!tckTaken) tckIn <= ~tckIn;
  end
  // whole clock periods, so n rises and n falls
  task automatic pulse(input int n);
    repeat (2 * n) begin
      repeat (2) @(posedge ref_clk);
      tckIn <= ~tckIn;
    end
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// >>> tb/tmc_timer_asserts.sv
// Purpose: port checks of the timer shell
// Assumes: one clock, synchronous reset
// Notes:   counter itself is not visible here
module tmc_timer_asserts (
  input wire logic              ref_clk,   // clock
  input wire logic              sys_rst,   // reset
  input wire tmc_pkg::tmc_bus_s bus,       // requests
  input wire logic [7:0]        rdata,     // read data
  input wire logic              tckTaken,  // pin claimed
  input wire tmc_pkg::tmc_pin_s pinDrive,  // pin drive
  input wire logic [3:0]        pinChoice, // choice bits
  input wire logic              irq        // interrupt
);
  import tmc_pkg::*;
  // ====================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire hiRd = bus.rd && bus.addr inside {A_CNT_H, A_CMPA_H, A_CMPP_H};
  wire ctlWr = bus.wr && bus.addr == A_CTRL;
  rd_idle_a:
    assert property (!bus.rd |=> rdata == 8'h00) else $error("rd idle");
  sel_read_a:
    assert property (bus.rd && bus.addr == A_PINSEL
      |=> rdata == {4'h0, $past(pinChoice)}) else $error("sel read");
  sel_write_a:
    assert property (bus.wr && bus.addr == A_PINSEL
      |=> pinChoice == $past(bus.wdata[3:0])) else $error("sel write");
  pin_excl_a:
    assert property (!(pinDrive.oe0 && pinDrive.oe1)) else $error("oe");
  pin_route_a:
    assert property (pinDrive.oe0 || pinDrive.oe1
      |-> pinDrive.oe1 == pinChoice[0]) else $error("pin route");
  clk_claim_a:
    assert property (ctlWr |=> tckTaken == ($past(bus.wdata[6:5]) == 2'h3))
      else $error("pin claim");
  off_release_a:
    assert property (ctlWr && !bus.wdata[CTRL_ON]
      |=> !pinDrive.oe0 && !pinDrive.oe1) else $error("off release");
  high_byte_a:
    assert property (hiRd |=> rdata[7:2] == 6'h00) else $error("high");
  cover property (irq);
  cover property (pinDrive.oe1);
  cover property (hiRd ##1 bus.rd);
endmodule
bind tmc_timer tmc_timer_asserts chk_u (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .tckTaken(tckTaken),
  .pinDrive(pinDrive), .pinChoice(pinChoice), .irq(irq));

// >>> tb/tb_tmc_timer.sv
// Purpose: self-checking bench of the timer shell
// Assumes: bus strobes one cycle, read data one cycle later
// Notes:   sub clock tick tied low; external pin used instead
module tb_tmc_timer;
  import tmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Harness
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  tmc_bus_s   bus = '0;
  logic [7:0] rdata;
  logic       tckIn, tckTaken, irq;
  tmc_pin_s   pinDrive;
  logic [3:0] pinChoice;
  int         fails = 0;
  int         tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  tmc_timer dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .subTick(1'b0), .tckIn(tckIn), .tckTaken(tckTaken),
    .pinDrive(pinDrive), .pinChoice(pinChoice), .irq(irq));
  tmc_pin_model pin_u (.ref_clk(ref_clk), .tckTaken(tckTaken),
    .tckIn(tckIn));
  task automatic chk(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Called just after an edge; idle edge after keeps one write per step
  task automatic wr(input tmc_addr_t a, input tmc_byte_t d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) bus <= '0;
    @(posedge ref_clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rc(input tmc_addr_t a, input tmc_byte_t e, string n);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) bus <= '0;
    #1 chk(n, e, rdata);
    @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Pin select register and pin routing
  task automatic t_regs();
    rc(A_PINSEL, 8'h00, "sel reset");
    wr(A_PINSEL, 8'hFF);
    rc(A_PINSEL, 8'h0F, "sel");
    rc(4'hF, 8'h00, "unmapped");
    wr(A_CTRL, 8'h18);
    #1 chk("oe1", 8'h01, {7'h0, pinDrive.oe1});
    chk("oe0", 8'h00, {7'h0, pinDrive.oe0});
    @(posedge ref_clk);
    wr(A_PINSEL, 8'h00);
    #1 chk("oe0", 8'h01, {7'h0, pinDrive.oe0});
    @(posedge ref_clk);
    wr(A_CTRL, 8'h00);
    $display("t_regs done");
  endtask
  // Buffered low byte of the compare pair
  task automatic t_pair();
    wr(A_CMPA_L, 8'h5A);
    rc(A_CMPA_H, 8'h00, "cmpA hi");
    rc(A_CMPA_L, 8'h00, "cmpA live lo");
    wr(A_CMPA_L, 8'h5A);
    wr(A_CMPA_H, 8'h02);
    rc(A_CMPA_H, 8'h02, "cmpA hi");
    rc(A_CMPA_L, 8'h5A, "cmpA lo");
    $display("t_pair done");
  endtask
  // External clock, both edges
  task automatic t_ext();
    tmc_byte_t s [2] = '{{1'b0, CK_EXTR, 4'h0}, {1'b0, CK_EXTF, 4'h0}};
    wr(A_MODE, 8'h01);
    foreach (s[i]) begin
      wr(A_CTRL, s[i]);
      wr(A_CTRL, s[i] | 8'h08);
      pin_u.pulse(5);
      rc(A_CNT_H, 8'h00, "cnt hi");
      rc(A_CNT_L, 8'h05, "cnt lo");
      wr(A_CTRL, 8'h00);
    end
    $display("t_ext done");
  endtask
  // Compare matches, interrupts and toggle output
  task automatic t_irq();
    // Turn-on at zero in t_regs hit both comparators; t_ext hit P
    rc(A_IRQST, 8'h03, "status stale");
    wr(A_IRQMSK, 8'h01);
    wr(A_CMPA_L, 8'h03);
    wr(A_CMPA_H, 8'h00);
    wr(A_CMPP_L, 8'h02);
    wr(A_CMPP_H, 8'h00);
    wr(A_MODE, 8'h31);
    wr(A_CTRL, 8'h60);
    wr(A_CTRL, 8'h68);
    pin_u.pulse(3);
    #1 chk("irq masked", 8'h00, {7'h0, irq});
    @(posedge ref_clk);
    rc(A_IRQST, 8'h02, "status P");
    pin_u.pulse(1);
    #1 chk("irq", 8'h01, {7'h0, irq});
    chk("out", 8'h01, {7'h0, pinDrive.out});
    @(posedge ref_clk);
    rc(A_IRQST, 8'h01, "status A");
    #1 chk("irq clr", 8'h00, {7'h0, irq});
    @(posedge ref_clk);
    rc(A_CNT_H, 8'h00, "cnt hi");
    rc(A_CNT_L, 8'h00, "cnt cleared");
    $display("t_irq done");
  endtask
  // PWM level on the timer pin: high below compare A, low at it
  task automatic t_pwm();
    wr(A_MODE, 8'hA1);
    #1 chk("pwm high", 8'h01, {7'h0, pinDrive.out});
    @(posedge ref_clk);
    pin_u.pulse(3);
    #1 chk("pwm low", 8'h00, {7'h0, pinDrive.out});
    @(posedge ref_clk);
    wr(A_CTRL, 8'h00);
    $display("t_pwm done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_pair();
    t_ext();
    t_irq();
    t_pwm();
    conclude();
  end
endmodule
